/* File: src/pmab_bank.sv */
// Read-only PHY management attribute bank with statistics and implementation constants.
// Assumes event inputs are synchronous to mclk_i and each high cycle is one event.
`timescale 1ns/1ns
`default_nettype none

module pmab_bank
  import pmab_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic phy_attribute_get_i,
  input wire logic [15:0] phy_attribute_id_i,
  output logic phy_attribute_done_o,
  output logic phy_attribute_error_o,
  output logic [31:0] phy_attribute_data_o,
  input wire logic rx_crc_fail_i,
  input wire logic rx_bad_protocol_i,
  input wire logic phy_send_request_i,
  input wire logic tx_queue_full_i,
  input wire logic rx_channel_data_i,
  input wire logic rx_queue_full_i,
  input wire logic rx_frame_good_i,
  input wire logic link_quality_report_i,
  input wire logic [2:0] link_quality_db_i
);

  typedef struct packed {
    logic done;
    logic error;
    logic [31:0] data;
    logic [15:0] blk_sum;
    logic [3:0] blk_cnt;
    logic [15:0] avg_evm;
  } pmab_bank_state_t;

  pmab_bank_state_t state;
  pmab_bank_state_t next_state;

  logic [15:0] stat16 [4];
  logic [3:0] stat16_inc;
  logic [15:0] crc_error_count;
  logic [15:0] bad_protocol_count;
  logic [15:0] tx_drop_count;
  logic [15:0] rx_drop_count;
  logic [31:0] good_frame_count;
  logic [6:0] quality_linear;
  logic [15:0] blk_total;
  logic signed [17:0] ema_diff;
  logic signed [17:0] ema_step;

  // Linear value of 2^(k/2) with three fraction bits, rounded to nearest except k=7, which gives 90 (0x5A) instead of 91.
  function automatic logic [6:0] db_to_linear(input logic [2:0] k);
    case (k)
      3'h0: db_to_linear = 7'h08;
      3'h1: db_to_linear = 7'h0B;
      3'h2: db_to_linear = 7'h10;
      3'h3: db_to_linear = 7'h17;
      3'h4: db_to_linear = 7'h20;
      3'h5: db_to_linear = 7'h2D;
      3'h6: db_to_linear = 7'h40;
      3'h7: db_to_linear = 7'h5A;
      default: db_to_linear = 7'h00;
    endcase
  endfunction

  // True only for identifiers that carry an attribute in this bank.
  function automatic logic attr_known(input logic [15:0] id);
    case (id)
      ID_CRC_ERROR, ID_BAD_PROTOCOL, ID_TX_DROP, ID_RX_DROP, ID_GOOD_FRAME,
      ID_AVG_EVM, ID_SMOOTH_DIV, ID_TX_QUEUE, ID_RX_QUEUE, ID_TX_LATENCY,
      ID_RX_LATENCY, ID_GAIN_FLOOR, ID_GAIN_STEP_SIZE, ID_GAIN_STEP_TOTAL: attr_known = 1'b1;
      default: attr_known = 1'b0;
    endcase
  endfunction

  // Statistics event strobes; drops are qualified by the matching queue state.
  assign stat16_inc[0] = rx_crc_fail_i;
  assign stat16_inc[1] = rx_bad_protocol_i;
  assign stat16_inc[2] = phy_send_request_i & tx_queue_full_i;
  assign stat16_inc[3] = rx_channel_data_i & rx_queue_full_i;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stat16
      pmab_sat_counter #(
        .WIDTH(16)
      ) u_cnt (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .inc_i(stat16_inc[gi]),
        .count_o(stat16[gi])
      );
    end
  endgenerate

  pmab_sat_counter #(
    .WIDTH(32)
  ) u_good_frames (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .inc_i(rx_frame_good_i),
    .count_o(good_frame_count)
  );

  assign crc_error_count = stat16[0];
  assign bad_protocol_count = stat16[1];
  assign tx_drop_count = stat16[2];
  assign rx_drop_count = stat16[3];

  assign quality_linear = db_to_linear(link_quality_db_i);
  assign blk_total = state.blk_sum + {9'h000, quality_linear};
  // A divider of zero makes the reported figure the plain 16-frame sum.
  assign ema_diff = $signed({2'b00, blk_total}) - $signed({2'b00, state.avg_evm});
  assign ema_step = ema_diff >>> SMOOTH_DIVIDER;

  always_comb begin
    next_state = state;
    next_state.done = phy_attribute_get_i;
    next_state.error = 1'b0;
    next_state.data = DATA_RESET;
    if (link_quality_report_i) begin
      if (state.blk_cnt == EVM_BLOCK_LAST) begin
        next_state.blk_cnt = 4'h0;
        next_state.blk_sum = EVM_RESET;
        next_state.avg_evm = state.avg_evm + ema_step[15:0];
      end else begin
        next_state.blk_cnt = state.blk_cnt + 4'h1;
        next_state.blk_sum = blk_total;
      end
    end
    // The bank has no write path, so every attribute is read-only.
    if (phy_attribute_get_i) begin
      // Vendor range holds nothing here; standard gaps stay reserved.
      if (phy_attribute_id_i[ID_VENDOR_BIT] || !attr_known(phy_attribute_id_i)) begin
        next_state.error = 1'b1;
      end else begin
        // Every field is zero-extended into the 32-bit data word.
        case (phy_attribute_id_i)
          ID_CRC_ERROR: next_state.data = {16'h0000, crc_error_count};
          ID_BAD_PROTOCOL: next_state.data = {16'h0000, bad_protocol_count};
          ID_TX_DROP: next_state.data = {16'h0000, tx_drop_count};
          ID_RX_DROP: next_state.data = {16'h0000, rx_drop_count};
          ID_GOOD_FRAME: next_state.data = good_frame_count;
          ID_AVG_EVM: next_state.data = {16'h0000, state.avg_evm};
          ID_SMOOTH_DIV: next_state.data = {24'h000000, SMOOTH_DIVIDER};
          ID_TX_QUEUE: next_state.data = {22'h000000, TX_QUEUE_DEPTH};
          ID_RX_QUEUE: next_state.data = {22'h000000, RX_QUEUE_DEPTH};
          ID_TX_LATENCY: next_state.data = {12'h000, TX_LATENCY_US};
          ID_RX_LATENCY: next_state.data = {12'h000, RX_LATENCY_US};
          ID_GAIN_FLOOR: next_state.data = {24'h000000, GAIN_FLOOR_DB};
          ID_GAIN_STEP_SIZE: next_state.data = {29'h00000000, GAIN_STEP_DB};
          ID_GAIN_STEP_TOTAL: next_state.data = {24'h000000, GAIN_STEP_COUNT};
          default: next_state.error = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state.done <= 1'b0;
      state.error <= 1'b0;
      state.data <= DATA_RESET;
      state.blk_sum <= EVM_RESET;
      state.blk_cnt <= 4'h0;
      state.avg_evm <= EVM_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign phy_attribute_done_o = state.done;
  assign phy_attribute_error_o = state.error;
  assign phy_attribute_data_o = state.data;

  // Every get is answered exactly one cycle later.
  AST_GET_ANSWER: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i |=> phy_attribute_done_o && $past(phy_attribute_get_i))
    else $error("get request not answered in one cycle");

  AST_NO_SPURIOUS_DONE: assert property (@(posedge mclk_i) disable iff (rst_i)
    !phy_attribute_get_i |=> !phy_attribute_done_o)
    else $error("answer without a get request");

  AST_VENDOR_ERROR: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && phy_attribute_id_i[15] |=> phy_attribute_error_o)
    else $error("vendor identifier did not report an error");

  AST_STANDARD_GAP_ERROR: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && !phy_attribute_id_i[15] && !attr_known(phy_attribute_id_i)
    |=> phy_attribute_error_o && (phy_attribute_data_o == 32'h00000000))
    else $error("reserved identifier returned data");

  AST_KNOWN_NO_ERROR: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && attr_known(phy_attribute_id_i) |=> !phy_attribute_error_o)
    else $error("defined attribute answered with error");

  AST_CRC_READBACK: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_CRC_ERROR)
    |=> phy_attribute_data_o == {16'h0000, $past(crc_error_count)})
    else $error("crc error count read back wrong");

  AST_TX_DROP_COUNT: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_send_request_i && tx_queue_full_i && (tx_drop_count != 16'hFFFF)
    |=> tx_drop_count == $past(tx_drop_count) + 16'h0001)
    else $error("transmit drop not counted");

  AST_TX_NO_DROP: assert property (@(posedge mclk_i) disable iff (rst_i)
    !tx_queue_full_i |=> $stable(tx_drop_count))
    else $error("transmit drop counted with queue not full");

  AST_RX_DROP_COUNT: assert property (@(posedge mclk_i) disable iff (rst_i)
    rx_channel_data_i && rx_queue_full_i && (rx_drop_count != 16'hFFFF)
    |=> rx_drop_count == $past(rx_drop_count) + 16'h0001)
    else $error("receive drop not counted");

  AST_GOOD_FRAME_COUNT: assert property (@(posedge mclk_i) disable iff (rst_i)
    rx_frame_good_i && (good_frame_count != 32'hFFFFFFFF)
    |=> good_frame_count == $past(good_frame_count) + 32'h00000001)
    else $error("good frame not counted");

  // Watches the counter that the long saturation run actually drives to all ones.
  AST_COUNT_SATURATES: assert property (@(posedge mclk_i) disable iff (rst_i)
    (crc_error_count == 16'hFFFF) |=> (crc_error_count == 16'hFFFF))
    else $error("statistics counter wrapped");

  AST_TX_DROP_SATURATES: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_drop_count == 16'hFFFF) |=> (tx_drop_count == 16'hFFFF))
    else $error("transmit drop counter wrapped");

  AST_EVM_BLOCK_WRAP: assert property (@(posedge mclk_i) disable iff (rst_i)
    link_quality_report_i && (state.blk_cnt == EVM_BLOCK_LAST)
    |=> (state.blk_cnt == 4'h0) && (state.blk_sum == 16'h0000))
    else $error("quality block did not close after 16 frames");

  AST_EVM_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(link_quality_report_i && (state.blk_cnt == EVM_BLOCK_LAST)) |=> $stable(state.avg_evm))
    else $error("averaged figure moved inside a block");

  AST_QUALITY_LINEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
    link_quality_report_i && (link_quality_db_i == 3'h6) |-> quality_linear == 7'h40)
    else $error("quality conversion wrong");

  AST_TX_QUEUE_CONST: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_TX_QUEUE)
    |=> phy_attribute_data_o == {22'h000000, TX_QUEUE_DEPTH})
    else $error("transmit queue depth read back wrong");

  AST_GAIN_FLOOR_LIMIT: assert property (@(posedge mclk_i) disable iff (rst_i)
    $signed(GAIN_FLOOR_DB) <= 0)
    else $error("minimum gain above 0dB");

  AST_GAIN_STEP_LIMIT: assert property (@(posedge mclk_i) disable iff (rst_i)
    int'(GAIN_STEP_DB) <= GAIN_STEP_MAX_DB)
    else $error("gain step above 6dB");

  AST_GAIN_RANGE: assert property (@(posedge mclk_i) disable iff (rst_i)
    int'($signed(GAIN_FLOOR_DB)) + (int'(GAIN_STEP_COUNT) - 1) * int'(GAIN_STEP_DB)
    >= GAIN_RANGE_MIN_DB)
    else $error("gain range below 21dB");

  AST_CRC_COUNT: assert property (@(posedge mclk_i) disable iff (rst_i)
    rx_crc_fail_i && (crc_error_count != 16'hFFFF)
    |=> crc_error_count == $past(crc_error_count) + 16'h0001)
    else $error("crc failure not counted");

  AST_BAD_PROTOCOL_COUNT: assert property (@(posedge mclk_i) disable iff (rst_i)
    rx_bad_protocol_i && (bad_protocol_count != 16'hFFFF)
    |=> bad_protocol_count == $past(bad_protocol_count) + 16'h0001)
    else $error("invalid protocol field not counted");

  AST_RX_NO_DROP: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rx_queue_full_i |=> $stable(rx_drop_count))
    else $error("receive drop counted with queue not full");

  AST_ERROR_WITH_DONE: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_error_o |-> phy_attribute_done_o)
    else $error("error flag raised without an answer");

  AST_ERROR_DATA_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_error_o |-> (phy_attribute_data_o == 32'h00000000))
    else $error("error answer carried data");

  AST_IDLE_DATA_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
    !phy_attribute_done_o |-> (phy_attribute_data_o == 32'h00000000))
    else $error("data shown without an answer");

  AST_GOOD_FRAME_READBACK: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_GOOD_FRAME)
    |=> phy_attribute_data_o == $past(good_frame_count))
    else $error("good frame count read back wrong");

  AST_EVM_READBACK: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_AVG_EVM)
    |=> phy_attribute_data_o == {16'h0000, $past(state.avg_evm)})
    else $error("averaged figure read back wrong");

  AST_SMOOTH_READBACK: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_SMOOTH_DIV)
    |=> phy_attribute_data_o == {24'h000000, SMOOTH_DIVIDER})
    else $error("smoothing divider read back wrong");

  AST_RX_QUEUE_CONST: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_RX_QUEUE)
    |=> phy_attribute_data_o == {22'h000000, RX_QUEUE_DEPTH})
    else $error("receive queue depth read back wrong");

  AST_TX_LATENCY_CONST: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_TX_LATENCY)
    |=> phy_attribute_data_o == {12'h000, TX_LATENCY_US})
    else $error("transmit latency read back wrong");

  AST_RX_LATENCY_CONST: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_RX_LATENCY)
    |=> phy_attribute_data_o == {12'h000, RX_LATENCY_US})
    else $error("receive latency read back wrong");

  AST_GAIN_STEP_READBACK: assert property (@(posedge mclk_i) disable iff (rst_i)
    phy_attribute_get_i && (phy_attribute_id_i == ID_GAIN_STEP_SIZE)
    |=> phy_attribute_data_o == {29'h00000000, GAIN_STEP_DB})
    else $error("gain step size read back wrong");

  AST_QUALITY_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
    link_quality_report_i && (link_quality_db_i == 3'h0) |-> quality_linear == 7'h08)
    else $error("quality conversion of zero wrong");

  // Inside a block each report must advance the count and add its linear value.
  AST_EVM_BLOCK_STEP: assert property (@(posedge mclk_i) disable iff (rst_i)
    link_quality_report_i && (state.blk_cnt != EVM_BLOCK_LAST)
    |=> (state.blk_cnt == $past(state.blk_cnt) + 4'h1) && (state.blk_sum == $past(blk_total)))
    else $error("quality block did not accumulate");

endmodule // pmab_bank

`default_nettype wire

/* File: src/pmab_pkg.sv */
// Package for the PHY management attribute bank: identifiers, constants and reset values.
// Assumes a single 50 MHz clock domain shared by every user of these definitions.
`default_nettype none

package pmab_pkg;

  localparam int unsigned CLK_MHZ = 50;

  localparam logic [15:0] ID_CRC_ERROR = 16'h00A0;
  localparam logic [15:0] ID_BAD_PROTOCOL = 16'h00A1;
  localparam logic [15:0] ID_TX_DROP = 16'h00A2;
  localparam logic [15:0] ID_RX_DROP = 16'h00A3;
  localparam logic [15:0] ID_GOOD_FRAME = 16'h00A4;
  localparam logic [15:0] ID_AVG_EVM = 16'h00A5;
  localparam logic [15:0] ID_SMOOTH_DIV = 16'h00A8;
  localparam logic [15:0] ID_TX_QUEUE = 16'h00B0;
  localparam logic [15:0] ID_RX_QUEUE = 16'h00B1;
  localparam logic [15:0] ID_TX_LATENCY = 16'h00B2;
  localparam logic [15:0] ID_RX_LATENCY = 16'h00B3;
  localparam logic [15:0] ID_GAIN_FLOOR = 16'h00B4;
  localparam logic [15:0] ID_GAIN_STEP_SIZE = 16'h00B5;
  localparam logic [15:0] ID_GAIN_STEP_TOTAL = 16'h00B6;

  // Top identifier bit separates the standard range from the vendor range.
  localparam int unsigned ID_VENDOR_BIT = 15;

  // Implementation constants of this PHY; they never change while running.
  localparam logic [9:0] TX_QUEUE_DEPTH = 10'h004;
  localparam logic [9:0] RX_QUEUE_DEPTH = 10'h004;
  localparam logic [19:0] TX_LATENCY_US = 20'h00064;
  localparam logic [19:0] RX_LATENCY_US = 20'h00064;
  localparam logic [7:0] GAIN_FLOOR_DB = 8'h00;
  localparam logic [2:0] GAIN_STEP_DB = 3'h3;
  localparam logic [7:0] GAIN_STEP_COUNT = 8'h08;
  localparam logic [7:0] SMOOTH_DIVIDER = 8'h00;
  localparam int GAIN_RANGE_MIN_DB = 21;
  localparam int GAIN_STEP_MAX_DB = 6;

  localparam logic [3:0] EVM_BLOCK_LAST = 4'hF;
  localparam logic [15:0] COUNT16_RESET = 16'h0000;
  localparam logic [31:0] COUNT32_RESET = 32'h00000000;
  localparam logic [15:0] EVM_RESET = 16'h0000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;

endpackage

`default_nettype wire

/* File: src/pmab_sat_counter.sv */
// Saturating event counter used for the statistics attributes.
// Assumes inc_i is a synchronous one-cycle-per-event level on mclk_i.
`timescale 1ns/1ns
`default_nettype none

module pmab_sat_counter #(
  parameter int WIDTH = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic inc_i,
  output logic [WIDTH-1:0] count_o
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } pmab_cnt_state_t;

  pmab_cnt_state_t state;
  pmab_cnt_state_t next_state;

  always_comb begin
    next_state = state;
    // Holding at all ones keeps a long-running count meaningful instead of wrapping.
    if (inc_i && (state.count != {WIDTH{1'b1}})) begin
      next_state.count = state.count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state.count <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count_o = state.count;

endmodule // pmab_sat_counter

`default_nettype wire

/* File: testbench/pmab_mgmt_model.sv */
// Management entity model that issues one attribute get at a time and collects the answer.
// Assumes the bank answers in the cycle after the edge that takes the request.
`timescale 1ns/1ns
`default_nettype none

module pmab_mgmt_model (
  input wire logic mclk_i,
  input wire logic done_i,
  input wire logic error_i,
  input wire logic [31:0] data_i,
  output logic get_o,
  output logic [15:0] id_o
);
  initial begin
    get_o = 1'b0;
    id_o = 16'h5A5A;
  end

  // The identifier is inverted on release so a stale value never looks like a fresh request.
  task automatic read(input logic [15:0] id, output logic ok, output logic err,
    output logic [31:0] data);
    @(negedge mclk_i);
    get_o = 1'b1;
    id_o = id;
    @(negedge mclk_i);
    get_o = 1'b0;
    id_o = ~id;
    ok = done_i;
    err = error_i;
    data = data_i;
  endtask
endmodule // pmab_mgmt_model

`default_nettype wire

/* File: testbench/phy_management_attribute_bank_tb.sv */
// Self-checking bench for the attribute bank: reference counters in integers, reads via the model.
// Assumes the package constants and a 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none

module phy_management_attribute_bank_tb;
  import pmab_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic crc = 1'b0, badp = 1'b0, send = 1'b0, txf = 1'b0, chd = 1'b0, rxf = 1'b0, good = 1'b0;
  logic qrep = 1'b0;
  logic [2:0] qdb = 3'h0;
  logic get, done, error;
  logic [15:0] id;
  logic [31:0] data;
  int unsigned cnt[5];
  int evm, blk_sum, blk_n, err_count, total_checks, cycles;
  int lin[8] = '{8, 11, 16, 23, 32, 45, 64, 90};
  logic [15:0] bad_ids[9] = '{16'h0000, 16'h009F, 16'h00A6, 16'h00A7, 16'h00A9, 16'h00B7,
    16'h7FFF, 16'h8000, 16'hFFFF};

  always #10 mclk = ~mclk;

  pmab_bank pmab_bank_i (.mclk_i(mclk), .rst_i(rst), .phy_attribute_get_i(get),
    .phy_attribute_id_i(id), .phy_attribute_done_o(done), .phy_attribute_error_o(error),
    .phy_attribute_data_o(data), .rx_crc_fail_i(crc), .rx_bad_protocol_i(badp),
    .phy_send_request_i(send), .tx_queue_full_i(txf), .rx_channel_data_i(chd),
    .rx_queue_full_i(rxf), .rx_frame_good_i(good), .link_quality_report_i(qrep),
    .link_quality_db_i(qdb));

  pmab_mgmt_model pmab_mgmt_model_i (.mclk_i(mclk), .done_i(done), .error_i(error),
    .data_i(data), .get_o(get), .id_o(id));

  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] aid, input logic exp_err, input logic [31:0] exp);
    logic ok, e;
    logic [31:0] d;
    pmab_mgmt_model_i.read(aid, ok, e, d);
    total_checks++;
    if (ok !== 1'b1 || e !== exp_err || d !== exp) begin
      err_count++;
      $display("mismatch t=%0t id=%h got %h/%h/%h exp 1/%h/%h", $time, aid, ok, e, d,
        exp_err, exp);
    end
  endtask

  task automatic check_stats();
    check(ID_CRC_ERROR, 1'b0, 32'(cnt[0]));
    check(ID_BAD_PROTOCOL, 1'b0, 32'(cnt[1]));
    check(ID_TX_DROP, 1'b0, 32'(cnt[2]));
    check(ID_RX_DROP, 1'b0, 32'(cnt[3]));
    check(ID_GOOD_FRAME, 1'b0, 32'(cnt[4]));
    check(ID_AVG_EVM, 1'b0, 32'(evm));
  endtask

  // Random events on the seven statistics event inputs; drops need the full level in the same cycle.
  task automatic events(input int n);
    repeat (n) begin
      @(negedge mclk);
      {crc, badp, send, txf, chd, rxf, good} = 7'($urandom);
      if (crc && cnt[0] < 65535) cnt[0]++;
      if (badp && cnt[1] < 65535) cnt[1]++;
      if (send && txf && cnt[2] < 65535) cnt[2]++;
      if (chd && rxf && cnt[3] < 65535) cnt[3]++;
      if (good) cnt[4]++;
    end
    @(negedge mclk);
    {crc, badp, send, txf, chd, rxf, good} = 7'h00;
  endtask

  task automatic quality(input int n);
    repeat (n) begin
      @(negedge mclk);
      qrep = 1'b1;
      qdb = 3'($urandom);
      blk_sum += lin[qdb];
      blk_n++;
      if (blk_n == 16) begin
        evm += (blk_sum - evm) >>> int'(SMOOTH_DIVIDER);
        blk_sum = 0;
        blk_n = 0;
      end
    end
    @(negedge mclk);
    qrep = 1'b0;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(75));
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    check_stats();
    check(ID_SMOOTH_DIV, 1'b0, 32'(SMOOTH_DIVIDER));
    check(ID_TX_QUEUE, 1'b0, 32'(TX_QUEUE_DEPTH));
    check(ID_RX_QUEUE, 1'b0, 32'(RX_QUEUE_DEPTH));
    check(ID_TX_LATENCY, 1'b0, 32'(TX_LATENCY_US));
    check(ID_RX_LATENCY, 1'b0, 32'(RX_LATENCY_US));
    check(ID_GAIN_FLOOR, 1'b0, 32'(GAIN_FLOOR_DB));
    check(ID_GAIN_STEP_SIZE, 1'b0, 32'(GAIN_STEP_DB));
    check(ID_GAIN_STEP_TOTAL, 1'b0, 32'(GAIN_STEP_COUNT));
    foreach (bad_ids[i]) check(bad_ids[i], 1'b1, 32'h0);
    check({1'b1, 15'($urandom)}, 1'b1, 32'h0);
    events(300);
    check_stats();
    // A partial block must leave the figure untouched; a full one updates it.
    quality(15);
    check(ID_AVG_EVM, 1'b0, 32'(evm));
    quality(1);
    check(ID_AVG_EVM, 1'b0, 32'(evm));
    quality(20);
    check(ID_AVG_EVM, 1'b0, 32'(evm));
    @(negedge mclk);
    crc = 1'b1;
    repeat (65540) @(negedge mclk);
    crc = 1'b0;
    cnt[0] = 65535;
    check(ID_CRC_ERROR, 1'b0, 32'(cnt[0]));
    check(ID_TX_QUEUE, 1'b0, 32'(TX_QUEUE_DEPTH));
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    foreach (cnt[i]) cnt[i] = 0;
    evm = 0;
    blk_sum = 0;
    blk_n = 0;
    check_stats();
    quality(16);
    check(ID_AVG_EVM, 1'b0, 32'(evm));
    conclude();
  end
endmodule // phy_management_attribute_bank_tb

`default_nettype wire
